// >>> src/pdmc_pkg.sv
// Package: constants and types of the power-down mode controller
package pdmc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [27:0] PDMC_CTRL_OFS     = 28'h5FFFFBC;
    localparam logic [27:0] PDMC_STAT_OFS     = 28'h5FFFFC0;
    localparam int          PDMC_SBY_BIT      = 7;
    localparam int          PDMC_HIZ_BIT      = 6;
    localparam logic [7:0]  PDMC_CTRL_RST     = 8'h1F;
    localparam logic [4:0]  PDMC_CTRL_ONES    = 5'h1F;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          PDMC_CLK_MHZ      = 125;
    localparam int          PDMC_WDT_STEP_NS  = 64;
    localparam int          PDMC_WDT_STEP_CYC =
        (PDMC_WDT_STEP_NS * PDMC_CLK_MHZ + 999) / 1000;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PDMC_RUN   = 2'h0,
        PDMC_SLEEP = 2'h1,
        PDMC_WARM  = 2'h3,
        PDMC_STBY  = 2'h2
    } pdmc_state_t;

    typedef enum logic [1:0] {
        PDMC_WK_NONE = 2'h0,
        PDMC_WK_IRQ  = 2'h1,
        PDMC_WK_DMA  = 2'h2,
        PDMC_WK_NMI  = 2'h3
    } pdmc_wake_t;
endpackage : pdmc_pkg

// >>> src/pdmc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pdmc_sync
    import pdmc_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Pin and filtered level
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;

    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s2_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            lvl_q <= INIT;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
endmodule : pdmc_sync

// >>> src/pdmc_wdt_wait.sv
// Watchdog settling wait after a standby wake-up
`timescale 1ns/1ps
module pdmc_wdt_wait
    import pdmc_pkg::*;
#(
    parameter int STEP_CYC = PDMC_WDT_STEP_CYC
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       start,
    input  wire logic [2:0] clk_sel,
    output logic            overflow
);
    logic [7:0]  pre_q;
    logic [7:0]  pre_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        run_q;
    logic        run_d;
    logic        ovf_q;
    logic        ovf_d;
    logic [15:0] limit;

    // Overflow interval doubles with each clock select step
    assign limit = 16'(16'h0100 << clk_sel);

    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        run_d = run_q;
        ovf_d = 1'b0;
        if (start) begin
            run_d = 1'b1;
            pre_d = 8'h00;
            cnt_d = 16'h0000;
        end else if (run_q) begin
            if (pre_q == 8'(STEP_CYC - 1)) begin
                pre_d = 8'h00;
                if (cnt_q == limit - 16'h0001) begin
                    run_d = 1'b0;
                    ovf_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end else begin
                pre_d = pre_q + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= 8'h00;
            cnt_q <= 16'h0000;
            run_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            run_q <= run_d;
            ovf_q <= ovf_d;
        end
    end

    assign overflow = ovf_q;
endmodule : pdmc_wdt_wait

// >>> src/pdmc_top.sv
// Power-down mode controller: sleep/standby entry, wake-up, control reg
`timescale 1ns/1ps
module pdmc_top
    import pdmc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [27:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // CPU core
    input  wire logic        halt_exec,
    input  wire logic [3:0]  cpu_status_reg_mask,
    output logic             cpu_hold,
    output logic             wake_req,
    output logic      [1:0]  wake_cause,
    // Interrupt unit and dma unit
    input  wire logic        irq_req,
    input  wire logic [3:0]  irq_level,
    input  wire logic        irq_enabled,
    input  wire logic        dma_addr_err,
    input  wire logic        nmi_edge_select,
    // Watchdog
    input  wire logic        watchdog_run_enable,
    input  wire logic [2:0]  watchdog_clock_select,
    // Pins
    input  wire logic        reset_input_n_pin,
    input  wire logic        nmi_pin,
    // Power and port control
    output logic             clk_gate_en,
    output logic             periph_clk_en,
    output logic             wdt_clk_en,
    output logic             port_float,
    output logic             por_reset,
    output logic             manual_reset
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic res_lvl;
    logic nmi_lvl;
    logic nmi_prev_q;

    pdmc_sync #(.INIT(1'b1)) u_res_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin     (reset_input_n_pin),
        .level   (res_lvl)
    );

    pdmc_sync #(.INIT(1'b0)) u_nmi_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin     (nmi_pin),
        .level   (nmi_lvl)
    );

    // ------------------------------------------------------------------
    // Wake event decode
    // ------------------------------------------------------------------
    logic nmi_rise;
    logic nmi_fall;
    logic nmi_valid;
    logic irq_ok;
    logic res_act;

    assign nmi_rise  = nmi_lvl & ~nmi_prev_q;
    assign nmi_fall  = ~nmi_lvl & nmi_prev_q;
    assign nmi_valid = nmi_edge_select ? nmi_rise
                                       : nmi_fall;
    assign irq_ok    = irq_req & irq_enabled
                     & (irq_level > cpu_status_reg_mask);
    assign res_act   = ~res_lvl;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic       sby_q;
    logic       sby_d;
    logic       hiz_q;
    logic       hiz_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] ctrl_val;
    logic       wr_ctrl;
    pdmc_state_t state_q;
    pdmc_state_t state_d;

    assign wr_ctrl  = reg_wr & (reg_addr == PDMC_CTRL_OFS);
    assign ctrl_val = {sby_q, hiz_q, 1'b0, PDMC_CTRL_ONES};

    always_comb begin
        sby_d = sby_q;
        hiz_d = hiz_q;
        if (res_act) begin
            sby_d = PDMC_CTRL_RST[PDMC_SBY_BIT];
            hiz_d = PDMC_CTRL_RST[PDMC_HIZ_BIT];
        end else if (wr_ctrl) begin
            // Setting is blocked while the watchdog runs; clearing is not
            if (!(reg_wdata[PDMC_SBY_BIT] && watchdog_run_enable)) begin
                sby_d = reg_wdata[PDMC_SBY_BIT];
            end
            if (!(reg_wdata[PDMC_HIZ_BIT] && watchdog_run_enable)) begin
                hiz_d = reg_wdata[PDMC_HIZ_BIT];
            end
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (reg_addr == PDMC_CTRL_OFS) begin
                rdata_d = ctrl_val;
            end else if (reg_addr == PDMC_STAT_OFS) begin
                rdata_d = {6'h00, state_q};
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------------
    pdmc_wake_t  cause_q;
    pdmc_wake_t  cause_d;
    logic        wake_q;
    logic        wake_d;
    logic        hold_q;
    logic        hold_d;
    logic        clk_q;
    logic        clk_d;
    logic        per_q;
    logic        per_d;
    logic        wdc_q;
    logic        wdc_d;
    logic        flt_q;
    logic        flt_d;
    logic        por_q;
    logic        por_d;
    logic        man_q;
    logic        man_d;
    logic        wdt_start;
    logic        wdt_ovf;

    pdmc_wdt_wait u_wdt_wait (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .start    (wdt_start),
        .clk_sel  (watchdog_clock_select),
        .overflow (wdt_ovf)
    );

    always_comb begin
        state_d   = state_q;
        cause_d   = PDMC_WK_NONE;
        wake_d    = 1'b0;
        wdt_start = 1'b0;
        por_d     = res_act & nmi_lvl;
        man_d     = res_act & ~nmi_lvl;
        if (res_act) begin
            state_d = PDMC_RUN;
        end else begin
            case (state_q)
                PDMC_RUN: begin
                    if (halt_exec) begin
                        state_d = sby_q ? PDMC_STBY
                                        : PDMC_SLEEP;
                    end
                end
                PDMC_SLEEP: begin
                    // Wake priority: NMI, DMA error, interrupt
                    if (nmi_valid) begin
                        state_d = PDMC_RUN;
                        cause_d = PDMC_WK_NMI;
                        wake_d  = 1'b1;
                    end else if (dma_addr_err) begin
                        state_d = PDMC_RUN;
                        cause_d = PDMC_WK_DMA;
                        wake_d  = 1'b1;
                    end else if (irq_ok) begin
                        state_d = PDMC_RUN;
                        cause_d = PDMC_WK_IRQ;
                        wake_d  = 1'b1;
                    end
                end
                PDMC_STBY: begin
                    if (nmi_valid) begin
                        state_d   = PDMC_WARM;
                        wdt_start = 1'b1;
                    end
                end
                PDMC_WARM: begin
                    if (wdt_ovf) begin
                        state_d = PDMC_RUN;
                        cause_d = PDMC_WK_NMI;
                        wake_d  = 1'b1;
                    end
                end
                default: begin
                    state_d = PDMC_RUN;
                end
            endcase
        end
        // CPU held in any power-down state; its registers are untouched
        hold_d = (state_d != PDMC_RUN);
        per_d  = (state_d == PDMC_RUN) || (state_d == PDMC_SLEEP);
        clk_d  = per_d;
        wdc_d  = (state_d != PDMC_STBY);
        flt_d  = hiz_q && (state_d == PDMC_STBY
                        || state_d == PDMC_WARM);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= PDMC_RUN;
            cause_q    <= PDMC_WK_NONE;
            wake_q     <= 1'b0;
            hold_q     <= 1'b0;
            clk_q      <= 1'b1;
            per_q      <= 1'b1;
            wdc_q      <= 1'b1;
            flt_q      <= 1'b0;
            por_q      <= 1'b0;
            man_q      <= 1'b0;
            nmi_prev_q <= 1'b0;
            sby_q      <= 1'b0;
            hiz_q      <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            state_q    <= state_d;
            cause_q    <= cause_d;
            wake_q     <= wake_d;
            hold_q     <= hold_d;
            clk_q      <= clk_d;
            per_q      <= per_d;
            wdc_q      <= wdc_d;
            flt_q      <= flt_d;
            por_q      <= por_d;
            man_q      <= man_d;
            nmi_prev_q <= nmi_lvl;
            sby_q      <= sby_d;
            hiz_q      <= hiz_d;
            rdata_q    <= rdata_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign cpu_hold      = hold_q;
    assign wake_req      = wake_q;
    assign wake_cause    = cause_q;
    assign clk_gate_en   = clk_q;
    assign periph_clk_en = per_q;
    assign wdt_clk_en    = wdc_q;
    assign port_float    = flt_q;
    assign por_reset     = por_q;
    assign manual_reset  = man_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence halt_seen_s;
        !res_act && state_q == PDMC_RUN && halt_exec;
    endsequence

    sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        halt_seen_s and !sby_q |=> state_q == PDMC_SLEEP)
        else $error("sleep not entered");
    stby_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        halt_seen_s and sby_q |=> state_q == PDMC_STBY && !per_q)
        else $error("standby not entered");
    sleep_periph_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == PDMC_SLEEP |-> per_q && hold_q)
        else $error("sleep peripheral clock wrong");
    irq_mask_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == PDMC_SLEEP && !res_act && !nmi_valid && !dma_addr_err
        && (!irq_enabled || irq_level <= cpu_status_reg_mask)
        |=> state_q == PDMC_SLEEP && !wake_q)
        else $error("masked interrupt woke sleep");
    dma_wake_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == PDMC_SLEEP && !res_act && !nmi_valid && dma_addr_err
        |=> wake_q && cause_q == PDMC_WK_DMA)
        else $error("dma error did not wake");
    por_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        res_act && nmi_lvl |=> por_q && !man_q && state_q == PDMC_RUN)
        else $error("power-on reset not entered");
    man_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        res_act && !nmi_lvl |=> man_q && !por_q)
        else $error("manual reset not entered");
    sby_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !sby_q && watchdog_run_enable |=> !sby_q)
        else $error("standby select set with watchdog on");
    hiz_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !hiz_q && watchdog_run_enable |=> !hiz_q)
        else $error("port float set with watchdog on");
    rsvd_bits_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_rd && reg_addr == PDMC_CTRL_OFS
        |=> reg_rdata[5:0] == 6'h1F)
        else $error("reserved bits read wrong");
    stby_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == PDMC_STBY && !res_act && !nmi_valid
        |=> state_q == PDMC_STBY)
        else $error("standby left without nmi or reset");
    warm_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == PDMC_WARM && !wdt_ovf && !res_act
        |=> state_q == PDMC_WARM && !clk_q)
        else $error("standby exit before overflow");
endmodule : pdmc_top

// >>> verif/pdmc_far.sv
// Far-side model: CPU core, interrupt unit, watchdog and pins
`timescale 1ns/1ps
module pdmc_far (
    // Clock and wake report
    input  wire logic       sys_clk,
    input  wire logic       wake_req,
    // CPU core and interrupt unit
    output logic            halt_exec,
    output logic      [3:0] cpu_status_reg_mask,
    output logic            irq_req,
    output logic      [3:0] irq_level,
    output logic            irq_enabled,
    output logic            dma_addr_err,
    output logic            nmi_edge_select,
    // Watchdog and pins
    output logic            watchdog_run_enable,
    output logic      [2:0] watchdog_clock_select,
    output logic            reset_input_n_pin,
    output logic            nmi_pin
);
    initial begin
        halt_exec = 1'b0;
        cpu_status_reg_mask = 4'h3;
        irq_req = 1'b0;
        irq_level = 4'h0;
        irq_enabled = 1'b0;
        dma_addr_err = 1'b0;
        nmi_edge_select = 1'b1;
        watchdog_run_enable = 1'b1;
        watchdog_clock_select = 3'h0;
        reset_input_n_pin = 1'b1;
        nmi_pin = 1'b0;
    end

    // Sources withdraw a request once it has been taken
    always @(posedge sys_clk) begin
        if (wake_req === 1'b1) begin
            irq_req      <= 1'b0;
            dma_addr_err <= 1'b0;
        end
    end

    task automatic halt();
        @(posedge sys_clk);
        halt_exec <= 1'b1;
        @(posedge sys_clk);
        halt_exec <= 1'b0;
        #1;
    endtask : halt

    task automatic irq(input logic en, input logic [3:0] lvl);
        @(posedge sys_clk);
        irq_req     <= 1'b1;
        irq_level   <= lvl;
        irq_enabled <= en;
    endtask : irq

    task automatic dma_err();
        @(posedge sys_clk);
        dma_addr_err <= 1'b1;
    endtask : dma_err

    task automatic pins(input logic rst_n, input logic nmi, input logic rise);
        @(posedge sys_clk);
        reset_input_n_pin <= rst_n;
        nmi_pin           <= nmi;
        nmi_edge_select   <= rise;
    endtask : pins

    // Software stops the watchdog before asking for standby
    task automatic wdt(input logic run);
        @(posedge sys_clk);
        watchdog_run_enable <= run;
    endtask : wdt

    // Overflow interval chosen before standby is entered
    task automatic wdt_sel(input logic [2:0] sel);
        @(posedge sys_clk);
        watchdog_clock_select <= sel;
    endtask : wdt_sel
endmodule : pdmc_far

// >>> verif/pdmc_bench.sv
// Self-checking bench of the power-down mode controller
`timescale 1ns/1ps
module pdmc_bench
    import pdmc_pkg::*;
;
    logic        sys_clk, nrst, reg_wr, reg_rd, halt_exec, cpu_hold;
    logic [27:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, flags;
    logic [3:0]  cpu_status_reg_mask, irq_level;
    logic [1:0]  wake_cause, cause_seen;
    logic        wake_req, irq_req, irq_enabled, dma_addr_err;
    logic        nmi_edge_select, watchdog_run_enable, reset_input_n_pin;
    logic [2:0]  watchdog_clock_select;
    logic        nmi_pin, clk_gate_en, periph_clk_en, wdt_clk_en;
    logic        port_float, por_reset, manual_reset;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;

    assign flags = {1'b0, manual_reset, por_reset, port_float, cpu_hold,
                    clk_gate_en, periph_clk_en, wdt_clk_en};

    pdmc_top pdmc_top_i (
        .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .halt_exec, .cpu_status_reg_mask, .cpu_hold,
        .wake_req, .wake_cause, .irq_req, .irq_level, .irq_enabled,
        .dma_addr_err, .nmi_edge_select, .watchdog_run_enable,
        .watchdog_clock_select, .reset_input_n_pin, .nmi_pin,
        .clk_gate_en, .periph_clk_en, .wdt_clk_en, .port_float,
        .por_reset, .manual_reset
    );
    pdmc_far pdmc_far_i (
        .sys_clk, .wake_req, .halt_exec, .cpu_status_reg_mask, .irq_req,
        .irq_level, .irq_enabled, .dma_addr_err, .nmi_edge_select,
        .watchdog_run_enable, .watchdog_clock_select, .reset_input_n_pin,
        .nmi_pin
    );

    initial begin
        sys_clk = 1'b0;
        forever begin
            #4 sys_clk = ~sys_clk;
        end
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [27:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [27:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd

    // Counts cycles until a wake pulse, giving up at the limit
    task automatic wait_wake(input int lim);
        cause_seen = 2'h0;
        for (n = 0; n < lim; n++) begin
            @(posedge sys_clk);
            #1;
            if (wake_req === 1'b1) begin
                cause_seen = wake_cause;
                return;
            end
        end
    endtask : wait_wake

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rd(PDMC_CTRL_OFS, PDMC_CTRL_RST);
        rd(PDMC_STAT_OFS, 8'h00);
        rd(28'h0000010, 8'h00);
        pdmc_far_i.wdt(1'b0);
        wr(PDMC_CTRL_OFS, 8'hFF);
        rd(PDMC_CTRL_OFS, 8'hDF);
        wr(PDMC_CTRL_OFS, 8'h80);
        pdmc_far_i.wdt(1'b1);
        wr(PDMC_CTRL_OFS, 8'hC0);
        rd(PDMC_CTRL_OFS, 8'h9F);
        wr(PDMC_CTRL_OFS, 8'h40);
        rd(PDMC_CTRL_OFS, 8'h1F);
    endtask : t_regs

    task automatic t_sleep();
        pdmc_far_i.irq(1'b0, 4'hF);
        pdmc_far_i.halt();
        check(flags, 8'h0F);
        rd(PDMC_STAT_OFS, 8'h01);
        wait_wake(20);
        check(8'(n), 8'h14);
        pdmc_far_i.irq(1'b1, 4'h3);
        wait_wake(20);
        check(8'(n), 8'h14);
        pdmc_far_i.irq(1'b1, 4'h4);
        wait_wake(20);
        check({cause_seen, flags[5:0]}, 8'h47);
        pdmc_far_i.halt();
        pdmc_far_i.dma_err();
        wait_wake(20);
        check({cause_seen, flags[5:0]}, 8'h87);
        for (int r = 1; r >= 0; r--) begin
            pdmc_far_i.pins(1'b1, ~r[0], r[0]);
            repeat (8) @(posedge sys_clk);
            pdmc_far_i.halt();
            pdmc_far_i.pins(1'b1, r[0], r[0]);
            wait_wake(20);
            check({cause_seen, flags[5:0]}, 8'hC7);
        end
    endtask : t_sleep

    task automatic t_standby();
        pdmc_far_i.pins(1'b1, 1'b1, 1'b0);
        pdmc_far_i.wdt(1'b0);
        wr(PDMC_CTRL_OFS, 8'hC0);
        repeat (8) @(posedge sys_clk);
        pdmc_far_i.halt();
        check(flags, 8'h18);
        pdmc_far_i.irq(1'b1, 4'hF);
        pdmc_far_i.dma_err();
        wait_wake(40);
        check(8'(n), 8'h28);
        pdmc_far_i.pins(1'b1, 1'b0, 1'b0);
        wait_wake(100);
        check(flags, 8'h19);
        wait_wake(2000);
        check({cause_seen, 5'h00, (n >= 1945 && n <= 1965)}, 8'hC1);
    endtask : t_standby

    task automatic t_resets();
        pdmc_far_i.pins(1'b1, 1'b1, 1'b0);
        wr(PDMC_CTRL_OFS, 8'h80);
        pdmc_far_i.halt();
        check(flags, 8'h08);
        pdmc_far_i.pins(1'b0, 1'b1, 1'b0);
        repeat (8) @(posedge sys_clk);
        check(flags, 8'h27);
        rd(PDMC_CTRL_OFS, 8'h1F);
        pdmc_far_i.pins(1'b1, 1'b1, 1'b1);
        repeat (8) @(posedge sys_clk);
        pdmc_far_i.halt();
        pdmc_far_i.pins(1'b1, 1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        check(flags, 8'h0F);
        pdmc_far_i.pins(1'b0, 1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        check(flags, 8'h47);
        pdmc_far_i.pins(1'b1, 1'b0, 1'b1);
    endtask : t_resets

    // Longer watchdog interval doubles the standby warm-up
    task automatic t_interval();
        repeat (8) @(posedge sys_clk);
        pdmc_far_i.wdt_sel(3'h1);
        wr(PDMC_CTRL_OFS, 8'h80);
        pdmc_far_i.halt();
        check(flags, 8'h08);
        pdmc_far_i.pins(1'b1, 1'b1, 1'b1);
        wait_wake(5000);
        check({cause_seen, 5'h00, (n >= 4090 && n <= 4110)}, 8'hC1);
    endtask : t_interval

    initial begin
        nrst      = 1'b0;
        reg_addr  = 28'h0000000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_sleep();
        t_standby();
        t_resets();
        t_interval();
        complete_run();
    end
endmodule : pdmc_bench
